/* File: rtl/dwfb_bank.sv */
`timescale 1ns/1ps
// Function
// - CAN low shorts latched, cleared after recovery.
// - CAN high shorts latched, cleared after recovery.
// - Pin 3 switch ground short, recovery clear.
// - Pin 2 switch ground short, recovery clear.
// - Parity error flag cleared by read.
// - Select low too long sets flag.
// - Supply 2 undervoltage, cleared after recovery.
// - Supply 1 overvoltage, cleared after recovery.
// - Pin 0 switch overtemperature, recovery clear.
// - Flash mode watchdog half-period pre-warning.
// - Wake on pin 1 or 3.
// - Wake on pin 0 or 2.
// - SPI wake from regulator-on low power.
// - Forced wake-up timer wake flag.
// - Interrupt service timeout error flag.
// - Regulator-off low power selected before wake.
// - SPI requested reset sets source flag.
// - Hardware debug exit sets flag.
module dwfb_bank
(
   input  wire logic                  mclk,         // System clock, 50 MHz.
   input  wire logic                  rst,          // Sync reset, high.
   input  wire logic                  spi_select_n, // Select pin, async.
   input  wire dwfb_pkg::dwfb_fault_s fault,        // Fault levels.
   input  wire dwfb_pkg::dwfb_event_s event_in,     // Event pulses.
   input  wire dwfb_pkg::dwfb_wdog_s  wdog,         // Watchdog state.
   input  wire dwfb_pkg::dwfb_read_s  rd,           // Flag read request.
   output dwfb_pkg::dwfb_flags_t      rd_data,      // Flags at last read.
   output logic                       rd_valid,     // Read data pulse.
   output dwfb_pkg::dwfb_flags_t      flags         // Live flag vector.
);

   typedef struct packed {
      dwfb_pkg::dwfb_flags_t flags;
      dwfb_pkg::dwfb_fault_s fault_s1;
      dwfb_pkg::dwfb_fault_s fault_s2;
      dwfb_pkg::dwfb_flags_t rd_data;
      logic                  rd_valid;
      logic                  half_seen;
   } dwfb_state_s;

   dwfb_state_s st_reg;
   dwfb_state_s st_next;

   logic                  sel_too_long;
   dwfb_pkg::dwfb_flags_t set_vec;
   dwfb_pkg::dwfb_flags_t active_vec;
   dwfb_pkg::dwfb_flags_t clear_ok;
   logic                  half_now;

   // Turns a fault struct into its place in the flag vector.
   function automatic dwfb_pkg::dwfb_flags_t fault_to_vec
   (
      input dwfb_pkg::dwfb_fault_s f
   );
      dwfb_pkg::dwfb_flags_t v;
      v = '0;
      v[dwfb_pkg::B_CANL_BAT] = f.canl_bat;
      v[dwfb_pkg::B_CANL_REG] = f.canl_reg;
      v[dwfb_pkg::B_CANL_GND] = f.canl_gnd;
      v[dwfb_pkg::B_CANH_BAT] = f.canh_bat;
      v[dwfb_pkg::B_CANH_REG] = f.canh_reg;
      v[dwfb_pkg::B_CANH_GND] = f.canh_gnd;
      v[dwfb_pkg::B_HS3_GND]  = f.hs3_gnd;
      v[dwfb_pkg::B_HS2_GND]  = f.hs2_gnd;
      v[dwfb_pkg::B_SUP2_UV]  = f.sup2_uv;
      v[dwfb_pkg::B_SUP1_OV]  = f.sup1_ov;
      v[dwfb_pkg::B_HS0_TEMP] = f.hs0_temp;
      return v;
   endfunction : fault_to_vec

   // Watches the select pin for an overlong low phase.
   dwfb_sel_watch u_sel_watch
   (
      .mclk        (mclk),
      .rst         (rst),
      .sel_n_async (spi_select_n),
      .too_long    (sel_too_long)
   );

   // Half-period check; only counts while in flash mode.
   assign half_now = wdog.flash_mode &&
                     ({1'b0, wdog.elapsed, 1'b0} >
                      {2'b00, wdog.period});

   // Set terms for every flag, from faults and events.
   always_comb
   begin
      set_vec = fault_to_vec(st_reg.fault_s2);
      // Supply and thermal faults feed their flags too.
      set_vec[dwfb_pkg::B_PARITY]     = event_in.parity_err;
      set_vec[dwfb_pkg::B_SEL_LONG]   = sel_too_long;
      set_vec[dwfb_pkg::B_WDOG_HALF]  = half_now &&
                                        !st_reg.half_seen;
      set_vec[dwfb_pkg::B_WAKE_13]    = event_in.wake_io1 ||
                                        event_in.wake_io3;
      set_vec[dwfb_pkg::B_WAKE_02]    = event_in.wake_io0 ||
                                        event_in.wake_io2;
      set_vec[dwfb_pkg::B_WAKE_SPI]   = event_in.wake_spi;
      set_vec[dwfb_pkg::B_WAKE_FORCE] = event_in.wake_forced;
      set_vec[dwfb_pkg::B_INT_TMO]    = event_in.int_timeout;
      set_vec[dwfb_pkg::B_LP_REGOFF]  = event_in.lp_regoff_sel;
      set_vec[dwfb_pkg::B_RST_REQ]    = event_in.spi_reset_done;
      set_vec[dwfb_pkg::B_DBG_EXIT]   = event_in.dbg_hw_exit;
   end

   // Faults still present block the clear of their flags.
   assign active_vec = fault_to_vec(st_reg.fault_s2);
   assign clear_ok   = rd.strobe ? (rd.sel & st_reg.flags &
                       ~(active_vec & dwfb_pkg::RECOVERY_MASK))
                       : '0;

   // Next state: synchronise faults, update flags, capture read data.
   always_comb
   begin
      st_next          = st_reg;
      st_next.fault_s1 = fault;
      st_next.fault_s2 = st_reg.fault_s1;
      st_next.half_seen = half_now;
      // Set wins over a clear landing in the same cycle.
      st_next.flags    = (st_reg.flags & ~clear_ok) | set_vec;
      st_next.rd_valid = rd.strobe;
      if (rd.strobe)
      begin
         st_next.rd_data = st_reg.flags & rd.sel;
      end
   end

   // State register.
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         st_reg <= '{flags: dwfb_pkg::FLAGS_RESET, fault_s1: '0,
                     fault_s2: '0, rd_data: '0, rd_valid: 1'b0,
                     half_seen: 1'b0};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign rd_data  = st_reg.rd_data;
   assign rd_valid = st_reg.rd_valid;
   assign flags    = st_reg.flags;

endmodule : dwfb_bank

/* File: rtl/dwfb_pkg.sv */
package dwfb_pkg;

   // Number of flags held in the bank.
   localparam int unsigned FLAG_COUNT = 22;

   // Bit positions of each flag in the flag vector.
   localparam int unsigned B_CANL_BAT   = 0;
   localparam int unsigned B_CANL_REG   = 1;
   localparam int unsigned B_CANL_GND   = 2;
   localparam int unsigned B_CANH_BAT   = 3;
   localparam int unsigned B_CANH_REG   = 4;
   localparam int unsigned B_CANH_GND   = 5;
   localparam int unsigned B_HS3_GND    = 6;
   localparam int unsigned B_HS2_GND    = 7;
   localparam int unsigned B_SUP2_UV    = 8;
   localparam int unsigned B_SUP1_OV    = 9;
   localparam int unsigned B_HS0_TEMP   = 10;
   localparam int unsigned B_PARITY     = 11;
   localparam int unsigned B_SEL_LONG   = 12;
   localparam int unsigned B_WDOG_HALF  = 13;
   localparam int unsigned B_WAKE_13    = 14;
   localparam int unsigned B_WAKE_02    = 15;
   localparam int unsigned B_WAKE_SPI   = 16;
   localparam int unsigned B_WAKE_FORCE = 17;
   localparam int unsigned B_INT_TMO    = 18;
   localparam int unsigned B_LP_REGOFF  = 19;
   localparam int unsigned B_RST_REQ    = 20;
   localparam int unsigned B_DBG_EXIT   = 21;

   // Flags that also need their fault gone before a read clears them.
   localparam logic [FLAG_COUNT-1:0] RECOVERY_MASK = 22'h0007ff;

   // Reset value of the flag vector.
   localparam logic [FLAG_COUNT-1:0] FLAGS_RESET = 22'h000000;

   // Select-low timeout and its cycle count at the 50 MHz clock.
   localparam int unsigned CLK_HZ        = 50000000;
   localparam int unsigned SEL_LOW_US    = 2000;
   localparam int unsigned SEL_LOW_CYC   = SEL_LOW_US * (CLK_HZ / 1000000);
   localparam int unsigned SEL_CNT_W     = 18;

   // Width of the watchdog period counters.
   localparam int unsigned WDOG_W = 16;

   typedef logic [FLAG_COUNT-1:0] dwfb_flags_t;

   // Raw condition levels from the analog and mode logic.
   typedef struct packed {
      logic canl_bat;
      logic canl_reg;
      logic canl_gnd;
      logic canh_bat;
      logic canh_reg;
      logic canh_gnd;
      logic hs3_gnd;
      logic hs2_gnd;
      logic sup2_uv;
      logic sup1_ov;
      logic hs0_temp;
   } dwfb_fault_s;

   // One-cycle event pulses from the device's own logic.
   typedef struct packed {
      logic parity_err;
      logic wake_io1;
      logic wake_io3;
      logic wake_io0;
      logic wake_io2;
      logic wake_spi;
      logic wake_forced;
      logic int_timeout;
      logic lp_regoff_sel;
      logic spi_reset_done;
      logic dbg_hw_exit;
   } dwfb_event_s;

   // Watchdog state seen by the pre-warning check.
   typedef struct packed {
      logic              flash_mode;
      logic [WDOG_W-1:0] period;
      logic [WDOG_W-1:0] elapsed;
   } dwfb_wdog_s;

   // Flag read request: a pulse and the flags it reads.
   typedef struct packed {
      logic        strobe;
      dwfb_flags_t sel;
   } dwfb_read_s;

endpackage : dwfb_pkg

/* File: rtl/dwfb_sel_watch.sv */
`timescale 1ns/1ps
// Watches the select pin and pulses once when it stays low too long.
module dwfb_sel_watch
(
   input  wire logic mclk,        // System clock.
   input  wire logic rst,         // Synchronous reset, active high.
   input  wire logic sel_n_async, // Select pin, outside the clock domain.
   output logic      too_long     // One-cycle pulse at the timeout.
);

   typedef struct packed {
      logic                          sync1;
      logic                          sync2;
      logic [dwfb_pkg::SEL_CNT_W-1:0] count;
      logic                          fired;
      logic                          pulse;
   } dwfb_sel_state_s;

   dwfb_sel_state_s st_reg;
   dwfb_sel_state_s st_next;

   localparam logic [dwfb_pkg::SEL_CNT_W-1:0] LIMIT =
      dwfb_pkg::SEL_CNT_W'(dwfb_pkg::SEL_LOW_CYC);

   // Two-stage synchroniser, then a low-time counter that fires once.
   always_comb
   begin
      st_next       = st_reg;
      st_next.sync1 = sel_n_async;
      st_next.sync2 = st_reg.sync1;
      st_next.pulse = 1'b0;
      if (st_reg.sync2)
      begin
         st_next.count = '0;
         st_next.fired = 1'b0;
      end
      else if (!st_reg.fired)
      begin
         if (st_reg.count >= LIMIT - 1'b1)
         begin
            st_next.fired = 1'b1;
            st_next.pulse = 1'b1;
         end
         else
         begin
            st_next.count = st_reg.count + 1'b1;
         end
      end
   end

   // State register.
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         st_reg <= '{sync1: 1'b1, sync2: 1'b1, count: '0,
                     fired: 1'b0, pulse: 1'b0};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign too_long = st_reg.pulse;

endmodule : dwfb_sel_watch

/* File: bench/dwfb_bank_monitor.sv */
`timescale 1ns/1ps
// Checks read timing and flag latching at the bank's ports.
module dwfb_bank_mon
(
   input wire logic                  mclk,         // Clock.
   input wire logic                  rst,          // Reset.
   input wire logic                  spi_select_n, // Select pin.
   input wire dwfb_pkg::dwfb_fault_s fault,        // Faults.
   input wire dwfb_pkg::dwfb_event_s event_in,     // Events.
   input wire dwfb_pkg::dwfb_wdog_s  wdog,         // Watchdog.
   input wire dwfb_pkg::dwfb_read_s  rd,           // Read request.
   input wire dwfb_pkg::dwfb_flags_t rd_data,      // Read data.
   input wire logic                  rd_valid,     // Read pulse.
   input wire dwfb_pkg::dwfb_flags_t flags         // Flags.
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   logic wd_half;
   // Watchdog strictly past half its period in flash mode.
   assign wd_half = wdog.flash_mode &&
                    ({wdog.elapsed, 1'b0} > {1'b0, wdog.period});
   int unsigned low_cnt;
   // Counts the clock edges for which the select pin has been low.
   always_ff @(posedge mclk)
   begin
      if (rst || spi_select_n)
      begin
         low_cnt <= '0;
      end
      else
      begin
         low_cnt <= low_cnt + 1'b1;
      end
   end
   // A fault held through both sync stages and the flag update.
   sequence flt_s;
      fault.canl_bat [*4];
   endsequence
   valid_pulse_a: assert property (rd.strobe |=> rd_valid)
      else $error("No read pulse after strobe.");
   valid_only_a: assert property (!rd.strobe |=> !rd_valid)
      else $error("Read pulse without strobe.");
   read_data_a: assert property (rd.strobe |=>
      rd_data == ($past(flags) & $past(rd.sel)))
      else $error("Read data not flags at strobe.");
   parity_set_a: assert property (event_in.parity_err |=> flags[11])
      else $error("Parity flag not set.");
   read_clear_a: assert property (
      rd.strobe && rd.sel[11] && !event_in.parity_err |=> !flags[11])
      else $error("Parity flag not cleared.");
   keep_unread_a: assert property (
      rd.strobe && !rd.sel[21] && flags[21] |=> flags[21])
      else $error("Unread flag cleared.");
   wake_pair_a: assert property (
      event_in.wake_io1 || event_in.wake_io3 |=> flags[14])
      else $error("Wake flag 1/3 not set.");
   fault_latch_a: assert property (flt_s |=> flags[0])
      else $error("Fault flag not held.");
   half_warn_a: assert property ($rose(wd_half) |-> ##[1:2] flags[13])
      else $error("Watchdog warning not set.");
   sel_long_a: assert property (
      low_cnt == dwfb_pkg::SEL_LOW_CYC + 2 |=> flags[12])
      else $error("Long select flag not set.");
endmodule : dwfb_bank_mon

bind dwfb_bank dwfb_bank_mon mon_u (.mclk, .rst, .spi_select_n, .fault,
   .event_in, .wdog, .rd, .rd_data, .rd_valid, .flags);

/* File: bench/dwfb_host.sv */
`timescale 1ns/1ps
// Host side: frames each flag read with the select pin.
module dwfb_host
(
   input  wire logic            mclk,        // Clock.
   output dwfb_pkg::dwfb_read_s rd,          // Read request.
   output logic                 spi_select_n // Select pin.
);
   // Idle: no request, select high.
   initial
   begin
      rd = '0;
      spi_select_n = 1'b1;
   end
   // Sixteen link periods of select low, far below the timeout.
   task read_flags(input dwfb_pkg::dwfb_flags_t sel);
      #160 spi_select_n = 1'b0;
      #2560;
      @(posedge mclk);
      #1 rd = {1'b1, sel};
      @(posedge mclk);
      #1 rd = '0;
      spi_select_n = 1'b1;
   endtask : read_flags
   // Drops the select pin and keeps it low for n clock edges.
   task hold_low(input int unsigned n);
      @(posedge mclk);
      #1 spi_select_n = 1'b0;
      repeat (n) @(posedge mclk);
      #1;
   endtask : hold_low
endmodule : dwfb_host

/* File: bench/test_dwfb_bank.sv */
`timescale 1ns/1ps
// Drives events, faults and reads; compares with a flag model.
module test_dwfb_bank;
   localparam int EV_MAP [11] = '{21,20,19,18,17,16,15,15,14,14,11};
   localparam logic [21:0] ALL = 22'h3fffff;
   logic                  mclk;
   logic                  rst;
   logic                  spi_select_n;
   dwfb_pkg::dwfb_fault_s fault;
   dwfb_pkg::dwfb_event_s event_in;
   dwfb_pkg::dwfb_wdog_s  wdog;
   dwfb_pkg::dwfb_read_s  rd;
   dwfb_pkg::dwfb_flags_t rd_data;
   logic                  rd_valid;
   dwfb_pkg::dwfb_flags_t flags;
   dwfb_pkg::dwfb_flags_t exp;
   int                    fail_count;
   int                    cmp_count;
   int                    seed;
   int                    i;

   dwfb_bank dut_u (.mclk, .rst, .spi_select_n, .fault, .event_in,
      .wdog, .rd, .rd_data, .rd_valid, .flags);
   dwfb_host host_u (.mclk, .rd, .spi_select_n);

   // Clock at 50 MHz.
   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // Flags that an event vector sets.
   function automatic logic [21:0] ev_flags(input logic [10:0] ev);
      logic [21:0] m;
      m = '0;
      for (int k = 0; k < 11; k++)
         if (ev[k]) m[EV_MAP[k]] = 1'b1;
      return m;
   endfunction : ev_flags

   // Compares one flag vector.
   task chk(input string what, input logic [21:0] e, g);
      cmp_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("MISMATCH %s exp %h got %h", what, e, g);
      end
   endtask : chk

   // One-cycle event pulse.
   task pulse(input logic [10:0] ev);
      event_in = ev;
      @(posedge mclk);
      #1 event_in = '0;
      exp |= ev_flags(ev);
   endtask : pulse

   // Read; flags whose fault persists stay set.
   task read(input logic [21:0] sel);
      logic [10:0] hold;
      hold = {<<{fault}};
      host_u.read_flags(sel);
      chk("rd_valid", 22'h1, {21'h0, rd_valid});
      chk("rd_data", exp & sel, rd_data);
      exp &= ~(sel & ~{11'h0, hold});
      chk("flags", exp, flags);
   endtask : read

   // Prints counts and the verdict, then stops.
   task final_report;
      $display("Compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report

   // Cuts a hang short.
   initial
   begin
      #3ms;
      fail_count++;
      final_report;
   end

   // Main sequence.
   initial
   begin
      seed = 86110;
      fail_count = 0;
      cmp_count = 0;
      exp = '0;
      rst = 1'b1;
      fault = '0;
      event_in = '0;
      wdog = '0;
      repeat (6) @(posedge mclk);
      #1 rst = 1'b0;
      chk("reset", dwfb_pkg::FLAGS_RESET, flags);
      for (i = 0; i < 19; i++)
      begin
         pulse(i < 11 ? 11'h1 << i : 11'($random(seed)));
         read(ALL);
      end
      $display("Events done");
      for (i = 0; i < 11; i++)
      begin
         fault = 11'h400 >> i;
         repeat (4) @(posedge mclk);
         #1 exp[i] = 1'b1;
         read(ALL);
         fault = '0;
         repeat (4) @(posedge mclk);
         #1 read(ALL);
      end
      $display("Faults done");
      pulse(11'h401);
      read(22'h000800);
      fork
         host_u.read_flags(ALL);
         begin
            #2720;
            @(posedge mclk);
            #1 pulse(11'h400);
         end
      join
      chk("rd_data", 22'h200000, rd_data);
      chk("flags", 22'h000800, flags);
      exp = 22'h000800;
      read(ALL);
      $display("Read order done");
      wdog = {1'b0, 16'h0010, 16'h00ff};
      @(posedge mclk);
      #1 wdog = {1'b1, 16'h0010, 16'h0008};
      repeat (3) @(posedge mclk);
      #1 chk("flags", exp, flags);
      wdog.elapsed = 16'h0009;
      repeat (3) @(posedge mclk);
      #1 exp[13] = 1'b1;
      read(ALL);
      $display("Watchdog done");
      host_u.hold_low(dwfb_pkg::SEL_LOW_CYC + 2);
      chk("sel_early", exp, flags);
      @(posedge mclk);
      #1 exp[dwfb_pkg::B_SEL_LONG] = 1'b1;
      chk("sel_long", exp, flags);
      read(ALL);
      $display("Select done");
      final_report;
   end
endmodule : test_dwfb_bank
